// ==== hdl/pstbl_regs.vh ====
`ifndef PSTBL_REGS_VH
`define PSTBL_REGS_VH
// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define PSTBL_OP_READ_LOW   2'h0
`define PSTBL_OP_READ_HIGH  2'h1
`define PSTBL_OP_WRITE_LOW  2'h2
`define PSTBL_OP_WRITE_HIGH 2'h3
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PSTBL_PAGE_CFG_BIT  7
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PSTBL_RESULT_RESET  16'h0000
`define PSTBL_FLAG_RESET    1'b0
`endif

// ==== hdl/pstbl_lane.v ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// one lane of the write merge: replaces a byte of the program word
// ----------------------------------------------------------------
module pstbl_lane #(
    parameter LANE_W = 8
) (
    // merge control
    input  wire              en,
    input  wire [LANE_W-1:0] old_byte,
    input  wire [LANE_W-1:0] new_byte,
    // result
    output wire [LANE_W-1:0] out_byte
);
    assign out_byte = en ? new_byte : old_byte;
endmodule

// ==== hdl/pstbl_access.v ====
`timescale 1ns/1ps
`include "pstbl_regs.vh"
module pstbl_access #(
    parameter OFS_W     = 16,
    parameter PAGE_W    = 8,
    parameter CFG_LIMIT = 24'h000100
) (
    // clock and reset
    input  wire                    clk,
    input  wire                    rst_n,
    // request from the core
    input  wire                    req_valid,
    input  wire [1:0]              op,
    input  wire                    byte_mode,
    input  wire [OFS_W-1:0]        offset,
    input  wire [PAGE_W-1:0]       table_page_select,
    input  wire [15:0]             wr_data,
    // program memory port
    output wire [PAGE_W+OFS_W-2:0] mem_addr,
    output wire                    mem_cfg_space,
    output wire                    mem_rd,
    input  wire [23:0]             mem_rdata,
    output wire                    mem_wr,
    output wire [23:0]             mem_wdata,
    // result to the core
    output reg                     done_ff,
    output reg                     refused_ff,
    output reg  [15:0]             rd_data_ff
);

    // ------------------------------------------------------------
    // derived widths
    // ------------------------------------------------------------
    localparam ADDR_W = PAGE_W + OFS_W - 1;
    localparam LANE_W = 8;
    // limit cut to the address width; its space bit is never set
    localparam [ADDR_W-1:0] CFG_LIM = CFG_LIMIT[ADDR_W-1:0];

    // ------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------
    wire is_rd_lo;
    wire is_rd_hi;
    wire is_wr_lo;
    wire is_wr_hi;
    wire is_write;
    wire is_high;
    wire byte_sel;

    assign is_rd_lo = (op == `PSTBL_OP_READ_LOW);
    assign is_rd_hi = (op == `PSTBL_OP_READ_HIGH);
    assign is_wr_lo = (op == `PSTBL_OP_WRITE_LOW);
    assign is_wr_hi = (op == `PSTBL_OP_WRITE_HIGH);
    assign is_write = is_wr_lo | is_wr_hi;
    assign is_high  = is_rd_hi | is_wr_hi;
    // same bit that picks a byte in a data-space address
    assign byte_sel = offset[0];

    // ------------------------------------------------------------
    // address and space
    // ------------------------------------------------------------
    wire              cfg;
    wire [ADDR_W-1:0] word_idx;

    assign cfg = table_page_select[`PSTBL_PAGE_CFG_BIT];
    // offset lsb is the byte select, so the index moves once per
    // two offset steps and each 24-bit word owns one offset pair
    assign word_idx = {table_page_select, offset[OFS_W-1:1]};

    // ------------------------------------------------------------
    // configuration space gate
    // ------------------------------------------------------------
    wire implemented;
    wire refuse;
    wire go;

    // only the index below the space bit counts against the limit
    assign implemented = ({1'b0, word_idx[ADDR_W-2:0]} < CFG_LIM);
    // user space is never refused; the limit bounds config reads only
    assign refuse = cfg & (is_write | ~implemented);
    assign go     = req_valid & ~refuse;

    // ------------------------------------------------------------
    // memory strobes
    // ------------------------------------------------------------
    // combinational: the memory answers within the request cycle
    assign mem_addr      = word_idx;
    assign mem_cfg_space = cfg;
    assign mem_rd        = go & ~is_write;
    assign mem_wr        = go & is_write;

    // ------------------------------------------------------------
    // write merge lane control
    // ------------------------------------------------------------
    // read-modify-write: untouched lanes keep the stored byte
    reg              en_lo;
    reg              en_mi;
    reg              en_hi;
    reg [LANE_W-1:0] mi_src;

    always @* begin
        en_lo  = 1'b0;
        en_mi  = 1'b0;
        en_hi  = 1'b0;
        mi_src = wr_data[15:8];
        if (is_wr_lo) begin
            if (!byte_mode) begin
                en_lo = 1'b1;
                en_mi = 1'b1;
            end else if (byte_sel) begin
                en_mi  = 1'b1;
                mi_src = wr_data[7:0];
            end else begin
                en_lo = 1'b1;
            end
        end else if (is_wr_hi) begin
            // phantom byte has no storage, so that write is dropped
            en_hi = ~(byte_mode & byte_sel);
        end
    end

    // ------------------------------------------------------------
    // byte lanes
    // ------------------------------------------------------------
    wire [LANE_W-1:0] b0;
    wire [LANE_W-1:0] b1;
    wire [LANE_W-1:0] b2;

    pstbl_lane #(
        .LANE_W   (LANE_W)
    ) u_lo (
        .en       (en_lo),
        .old_byte (mem_rdata[7:0]),
        .new_byte (wr_data[7:0]),
        .out_byte (b0)
    );

    pstbl_lane #(
        .LANE_W   (LANE_W)
    ) u_mi (
        .en       (en_mi),
        .old_byte (mem_rdata[15:8]),
        .new_byte (mi_src),
        .out_byte (b1)
    );

    pstbl_lane #(
        .LANE_W   (LANE_W)
    ) u_hi (
        .en       (en_hi),
        .old_byte (mem_rdata[23:16]),
        .new_byte (wr_data[7:0]),
        .out_byte (b2)
    );

    // upper lane is only ever enabled by the high write op
    assign mem_wdata = {b2, b1, b0};

    // ------------------------------------------------------------
    // read formatting
    // ------------------------------------------------------------
    // holds unless a read is taken, so refused reads leave no trace
    reg [15:0] nxt_rd_data;

    always @* begin
        nxt_rd_data = rd_data_ff;
        if (mem_rd) begin
            case ({is_high, byte_mode, byte_sel})
                3'h0: begin
                    nxt_rd_data = mem_rdata[15:0];
                end
                3'h1: begin
                    nxt_rd_data = mem_rdata[15:0];
                end
                3'h2: begin
                    nxt_rd_data = {8'h00, mem_rdata[7:0]};
                end
                3'h3: begin
                    nxt_rd_data = {8'h00, mem_rdata[15:8]};
                end
                3'h4: begin
                    // phantom byte d15:8 always reads as zero
                    nxt_rd_data = {8'h00, mem_rdata[23:16]};
                end
                3'h5: begin
                    nxt_rd_data = {8'h00, mem_rdata[23:16]};
                end
                3'h6: begin
                    nxt_rd_data = {8'h00, mem_rdata[23:16]};
                end
                default: begin
                    // byte select on the phantom byte
                    nxt_rd_data = 16'h0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // result registers
    // ------------------------------------------------------------
    // every request is answered next cycle, refused or not
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_ff <= `PSTBL_FLAG_RESET;
        end else begin
            done_ff <= req_valid;
        end
    end

    // tells the core that nothing reached the memory
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            refused_ff <= `PSTBL_FLAG_RESET;
        end else begin
            refused_ff <= req_valid & refuse;
        end
    end

    // kept until the next taken read, so the core may fetch it late
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= `PSTBL_RESULT_RESET;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

endmodule

// ==== verif/pstbl_mem_model.sv ====
`timescale 1ns/1ps
// program memory seen by the block; async read, write on the edge
module pstbl_mem_model (
    input  logic        clk,
    input  logic [22:0] mem_addr,
    input  logic        mem_rd, mem_wr,
    input  logic [23:0] mem_wdata,
    output logic [23:0] mem_rdata
);
    logic [23:0] mem_ff [0:15];
    initial foreach (mem_ff[k]) mem_ff[k] = 24'h9e3779 * (k + 1);
    // unselected: inverted word, so stale data never looks valid
    assign mem_rdata = (mem_rd | mem_wr) ? mem_ff[mem_addr[3:0]]
                                         : ~mem_ff[mem_addr[3:0]];
    always @(posedge clk) if (mem_wr) mem_ff[mem_addr[3:0]] <= mem_wdata;
endmodule

// ==== verif/pstbl_access_props.sv ====
`timescale 1ns/1ps
module pstbl_access_props (
    // core side
    input logic clk, rst_n, req_valid, byte_mode,
    input logic [1:0] op, input logic [15:0] offset,
    input logic [7:0] table_page_select,
    // memory side and result
    input logic [22:0] mem_addr, input logic [23:0] mem_rdata,
    input logic [15:0] wr_data, input logic [23:0] mem_wdata,
    input logic mem_cfg_space, mem_rd, mem_wr, done_ff, refused_ff,
    input logic [15:0] rd_data_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd(o, b); req_valid && mem_rd && op == o && byte_mode == b;
    endsequence
    property p_ans; req_valid |=> done_ff; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_pg; mem_cfg_space == table_page_select[7]; endproperty
    a_pg: assert property (p_pg) else $error("bad space");
    property p_ad; req_valid |-> mem_addr == {table_page_select,
        offset[15:1]}; endproperty
    a_ad: assert property (p_ad) else $error("bad address");
    property p_wr; req_valid && op[1] && table_page_select[7] |->
        !mem_wr ##1 refused_ff; endproperty
    a_wr: assert property (p_wr) else $error("cfg write taken");
    property p_lw; s_rd(0, 0) |=> rd_data_ff == $past(mem_rdata[15:0]);
    endproperty
    a_lw: assert property (p_lw) else $error("bad low word");
    property p_hw; s_rd(1, 0) |=> rd_data_ff ==
        {8'h00, $past(mem_rdata[23:16])}; endproperty
    a_hw: assert property (p_hw) else $error("bad high word");
    property p_lb; s_rd(0, 1) |=> rd_data_ff[7:0] == ($past(offset[0])
        ? $past(mem_rdata[15:8]) : $past(mem_rdata[7:0])); endproperty
    a_lb: assert property (p_lb) else $error("bad low byte");
    property p_hb; s_rd(1, 1) |=> rd_data_ff[7:0] ==
        ($past(offset[0]) ? 8'h00 : $past(mem_rdata[23:16])); endproperty
    a_hb: assert property (p_hb) else $error("bad high byte");
    sequence s_wr(o, b); req_valid && mem_wr && op == o && byte_mode == b;
    endsequence
    property p_wl; s_wr(2, 0) |->
        mem_wdata == {mem_rdata[23:16], wr_data}; endproperty
    a_wl: assert property (p_wl) else $error("bad low word write");
    property p_up; s_wr(2, 1) |->
        mem_wdata[23:16] == mem_rdata[23:16]; endproperty
    a_up: assert property (p_up) else $error("upper byte hit");
    property p_wh; s_wr(3, 0) |->
        mem_wdata == {wr_data[7:0], mem_rdata[15:0]}; endproperty
    a_wh: assert property (p_wh) else $error("bad high write");
endmodule
bind pstbl_access pstbl_access_props pstbl_access_props_i (.clk, .rst_n,
    .req_valid, .byte_mode, .op, .offset, .table_page_select, .mem_addr,
    .mem_rdata, .mem_cfg_space, .mem_rd, .mem_wr, .done_ff, .refused_ff,
    .rd_data_ff, .wr_data, .mem_wdata);

// ==== verif/test_program_space_table_access.sv ====
`timescale 1ns/1ps
module test_program_space_table_access;
    logic        clk, rst_n, req_valid, byte_mode, mem_cfg_space, mem_rd;
    logic        mem_wr, done_ff, refused_ff;
    // request taken at the last edge and what the bench saw with it
    logic        q_v, q_wr, q_hi, q_b, q_s, q_ref, q_acc;
    logic [1:0]  op;
    logic [7:0]  table_page_select;
    logic [15:0] offset, wr_data, rd_data_ff, q_d, q_rd;
    logic [22:0] mem_addr;
    logic [23:0] mem_rdata, mem_wdata, q_p, q_wd;
    int          errors, total_checks;
    pstbl_access pstbl_access_i (.clk, .rst_n, .req_valid, .op, .byte_mode,
        .offset, .table_page_select, .wr_data, .mem_addr, .mem_cfg_space,
        .mem_rd, .mem_rdata, .mem_wr, .mem_wdata, .done_ff, .refused_ff,
        .rd_data_ff);
    pstbl_mem_model pstbl_mem_model_i (.clk, .mem_addr, .mem_rd, .mem_wr,
        .mem_wdata, .mem_rdata);
    function logic [15:0] ex(input logic hi, b, s, input logic [23:0] p);
        if (!hi) ex = b ? {8'h00, s ? p[15:8] : p[7:0]} : p[15:0];
        else ex = {8'h00, (b & s) ? 8'h00 : p[23:16]};
    endfunction
    // merged word a write must hand to memory
    function logic [23:0] exw(input logic hi, b, s, input logic [15:0] d,
                              input logic [23:0] p);
        if (hi) exw = (b & s) ? p : {d[7:0], p[15:0]};
        else if (!b) exw = {p[23:16], d};
        else exw = s ? {p[23:16], d[7:0], p[7:0]} : {p[23:8], d[7:0]};
    endfunction
    task check(input string n, input logic [23:0] e, s);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task drive(input logic v, input logic [1:0] o, input logic b,
               input logic [15:0] a, input logic [7:0] pg);
        @(posedge clk);
        req_valid <= v;
        op <= o;
        byte_mode <= b;
        offset <= a;
        table_page_select <= pg;
        wr_data <= 16'($urandom);
    endtask
    always @(posedge clk) begin
        {q_v, q_wr, q_hi, q_b, q_s} <= {req_valid, op, byte_mode,
            offset[0]};
        {q_p, q_d, q_wd, q_rd} <= {mem_rdata, wr_data, mem_wdata,
            rd_data_ff};
        q_acc <= mem_rd | mem_wr;
        q_ref <= req_valid & table_page_select[7] & (op[1] |
            ({table_page_select[6:0], offset[15:1]} >= 22'h100));
    end
    // byte forms only define the low data byte
    always @(negedge clk) if (rst_n) begin
        check("done", {23'h0, q_v}, {23'h0, done_ff});
        check("refused", {23'h0, q_ref}, {23'h0, refused_ff});
        check("access", {23'h0, q_v & ~q_ref}, {23'h0, q_acc});
        if (q_v && !q_ref && !q_wr)
            check("rd_data", ex(q_hi, q_b, q_s, q_p) &
                  (q_b ? 16'h00ff : 16'hffff),
                  rd_data_ff & (q_b ? 16'h00ff : 16'hffff));
        else
            check("rd_data hold", q_rd, rd_data_ff);
        if (q_v && !q_ref && q_wr)
            check("mem_wdata", exw(q_hi, q_b, q_s, q_d, q_p), q_wd);
    end
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst_n, req_valid, op, byte_mode, offset} = '0;
        {table_page_select, wr_data, errors, total_checks} = '0;
        void'($urandom(91541));
        repeat (4) @(posedge clk);
        rst_n <= 1;
        // corners: config reads, refused config writes, both selects
        for (int i = 0; i < 16; i++)
            drive(1'b1, i[1:0], i[2], {15'h0, i[3]}, i < 8 ? 8'h80 : 8'h01);
        // last implemented config word, then the first missing one
        drive(1'b1, 2'h0, 1'b0, 16'h01fe, 8'h80);
        drive(1'b1, 2'h1, 1'b0, 16'h0200, 8'h80);
        for (int i = 0; i < 800; i++)
            drive(2'($urandom) != 0, 2'($urandom), 1'($urandom),
                  16'($urandom), 8'($urandom));
        drive(1'b0, 2'h0, 1'b0, 16'h0000, 8'h00);
        repeat (2) @(posedge clk);
        $display("test random table ops done");
        // mid-run reset: results clear at once
        rst_n <= 0;
        @(negedge clk);
        check("done in reset", 24'h0, {23'h0, done_ff});
        check("refused in reset", 24'h0, {23'h0, refused_ff});
        check("rd_data in reset", 24'h0, {8'h00, rd_data_ff});
        repeat (3) @(posedge clk);
        rst_n <= 1;
        for (int i = 0; i < 8; i++)
            drive(1'b1, {1'b0, i[0]}, i[1], 16'($urandom), 8'h01);
        drive(1'b0, 2'h0, 1'b0, 16'h0000, 8'h00);
        repeat (2) @(posedge clk);
        $display("test reset recovery done");
        give_verdict;
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
endmodule
